// File: logic/dsr_pkg.sv
// constants, types and carriers for the disk rate and input status registers
// Overview of operation
// - the drive input view is read-only; config writes at its address alter the rate and precomp bits it shows
// - baseline read drives only bit seven; bits zero to six stay undriven
// - bit seven of every input view returns the inverse of disk changed
// - enhanced bit zero is low at 500k or 1M, high otherwise; resets one
// - enhanced bits two and one return rate select; bits three to six one
// - rate select survives soft reset; hardware reset loads 250k, code 10
// - legacy bit two returns the stored precompensation-off flag; resets 0
// - legacy bit three mirrors the output register dma gate enable
// - legacy bits four to six read zero; bits one and zero give rate
// - config write loads bits one and zero into rate select; write-only
// - legacy config bit two stores precomp off; no effect; soft reset keeps
// - density pin follows rate, high on hardware reset, no soft effect
// - result phase presents the first status byte through data register
// - status bits seven and six carry the termination code
// - status bit five flags a finished seek, relative seek or recalibrate
// - status bit four flags fault: 80 steps, no track zero, or past zero
// - status bit three zero, bit two head, bits one and zero drive number
package dsr_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] DSR_ADDR_INPUT_VIEW = 10'h3f7;
  localparam logic [9:0] DSR_ADDR_RATE_CFG = 10'h3f7;
  localparam logic [9:0] DSR_ADDR_DATA = 10'h3f5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DSR_CHG_BIT = 7;
  localparam int DSR_DMA_BIT = 3;
  localparam int DSR_PRECOMP_BIT = 2;
  localparam int DSR_NHD_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] DSR_RATE_RST = 2'h2;
  localparam logic DSR_PRECOMP_RST = 1'h0;
  localparam logic DSR_DENS_RST = 1'h1;

  // ----------------------------------------------------------------
  // termination codes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] DSR_TC_NORMAL = 2'h0;
  localparam logic [1:0] DSR_TC_ABNORMAL = 2'h1;
  localparam logic [1:0] DSR_TC_INVALID = 2'h2;
  localparam logic [1:0] DSR_TC_POLLING = 2'h3;
  localparam int DSR_RECAL_STEPS = 80;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DSR_BASE, DSR_ENH, DSR_LEGACY} dsr_mode_e;

  typedef struct packed {
    logic [9:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] din;
  } dsr_bus_s;

  typedef struct packed {
    logic [1:0] termination_code;
    logic seek_done;
    logic head;
    logic [1:0] drive_number;
    logic cmd_start;
    logic recal_start;
    logic step;
    logic past_zero;
  } dsr_st0_src_s;

endpackage : dsr_pkg

// File: logic/dsr_st0.sv
// first result status byte encoder with equipment fault detection
`timescale 1ns/10ps
module dsr_st0 import dsr_pkg::*; #(
  parameter int STEP_W = 7
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command engine and drive
  input wire dsr_st0_src_s src,
  input wire logic track_zero,
  // status byte
  output logic [7:0] st0
);

  if ((2 ** STEP_W) <= DSR_RECAL_STEPS) begin : g_step_chk
    $error("dsr_st0: STEP_W too small for step count");
  end

  localparam logic [STEP_W-1:0] STEP_LIMIT = STEP_W'(DSR_RECAL_STEPS);

  typedef struct packed {
    logic recal;
    logic [STEP_W-1:0] cnt;
    logic fault;
    logic [7:0] st0;
  } dsr_st0_s;

  dsr_st0_s st;
  dsr_st0_s next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // fault cleared per command
    if (src.cmd_start) begin
      next_st.fault = 1'b0;
    end
    if (src.recal_start) begin
      next_st.recal = 1'b1;
      next_st.cnt = '0;
    end else if (st.recal && track_zero) begin
      next_st.recal = 1'b0;
    end else if (st.recal && src.step) begin
      next_st.cnt = st.cnt + 1'b1;
    end
    if (st.recal && !track_zero && st.cnt == STEP_LIMIT) begin
      next_st.fault = 1'b1;
      next_st.recal = 1'b0;
    end
    if (src.past_zero) begin
      next_st.fault = 1'b1;
    end
    next_st.st0 = {src.termination_code, src.seek_done, st.fault,
                   1'b0, src.head, src.drive_number};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign st0 = st.st0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  step_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st.recal && !track_zero && st.cnt == STEP_LIMIT |=> st.fault)
    else $error("no fault after recalibrate step limit");
  zero_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
    src.past_zero |=> ##1 st0[4])
    else $error("step past zero not flagged");
  bit_three_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st0[3] == 1'b0 && st0[2] == $past(src.head))
    else $error("status bit three or head wrong");
  term_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st0[7:6] == $past(src.termination_code)
    && st0[5] == $past(src.seek_done))
    else $error("termination code or seek flag wrong");
  fault_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(st.fault));

endmodule : dsr_st0

// File: logic/dsr_regs.sv
// rate select, drive input views and status byte host access
`timescale 1ns/10ps
module dsr_regs import dsr_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // host bus pins
  input wire dsr_bus_s host_bus,
  output logic [7:0] host_dout,
  output logic [7:0] host_doe,
  // controller configuration
  input wire dsr_mode_e mode,
  input wire logic soft_reset,
  input wire logic dma_gate_enable,
  input wire logic result_phase,
  // drive interface pins
  input wire logic disk_changed,
  input wire logic track_zero_pin,
  output logic density_select_pin,
  // command engine
  input wire dsr_st0_src_s st0_src,
  output logic [1:0] rate_select,
  output logic precomp_off
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // high for the two slow rates, low for 500k and 1M
  function automatic logic low_rate(input logic [1:0] r);
    low_rate = r[1] ^ r[0];
  endfunction : low_rate

  function automatic logic [7:0] input_view(
    input dsr_mode_e m,
    input logic chg,
    input logic [1:0] r,
    input logic pc,
    input logic dma
  );
    logic [7:0] v;
    v = 8'h00;
    v[DSR_CHG_BIT] = ~chg;
    case (m)
      DSR_ENH: begin
        v[6:3] = 4'hf;
        v[2:1] = r;
        v[DSR_NHD_BIT] = low_rate(r);
      end
      DSR_LEGACY: begin
        v[6:4] = 3'h0;
        v[1:0] = r;
        v[DSR_PRECOMP_BIT] = pc;
        v[DSR_DMA_BIT] = dma;
      end
      default: begin
        v[6:0] = 7'h00;
      end
    endcase
    input_view = v;
  endfunction : input_view

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dsr_bus_s b1;
    dsr_bus_s b2;
    dsr_bus_s b3;
    dsr_bus_s bs;
    logic wr_prev;
    logic [2:0] chg_sync;
    logic chg;
    logic [2:0] trk_sync;
    logic trk;
    logic [1:0] rate;
    logic precomp;
    logic density;
    logic [7:0] dout;
    logic [7:0] doe;
  } dsr_state_s;

  localparam dsr_bus_s BUS_IDLE = '{addr: 10'h000, rd_n: 1'b1,
                                    wr_n: 1'b1, din: 8'h00};

  dsr_state_s st;
  dsr_state_s next_st;
  logic [7:0] st0_byte;
  logic cfg_write;
  logic view_read;
  logic data_read;

  // ----------------------------------------------------------------
  // status byte encoder
  // ----------------------------------------------------------------
  dsr_st0 #(
    .STEP_W(7)
  ) dsr_st0_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .src(st0_src),
    .track_zero(st.trk),
    .st0(st0_byte)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    cfg_write = 1'b0;
    view_read = 1'b0;
    data_read = 1'b0;
    if (!st.bs.wr_n && st.wr_prev
        && st.bs.addr == DSR_ADDR_RATE_CFG) begin
      cfg_write = 1'b1;
    end else if (!st.bs.rd_n && st.bs.addr == DSR_ADDR_INPUT_VIEW) begin
      view_read = 1'b1;
    end else if (!st.bs.rd_n && st.bs.addr == DSR_ADDR_DATA
                 && result_phase) begin
      data_read = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // pin synchronisers, change taken when stages two and three agree
    next_st.b1 = host_bus;
    next_st.b2 = st.b1;
    next_st.b3 = st.b2;
    if (st.b2 == st.b3) begin
      next_st.bs = st.b3;
    end
    next_st.wr_prev = st.bs.wr_n;
    next_st.chg_sync = {st.chg_sync[1:0], disk_changed};
    if (st.chg_sync[1] == st.chg_sync[2]) begin
      next_st.chg = st.chg_sync[2];
    end
    next_st.trk_sync = {st.trk_sync[1:0], track_zero_pin};
    if (st.trk_sync[1] == st.trk_sync[2]) begin
      next_st.trk = st.trk_sync[2];
    end
    if (cfg_write) begin
      next_st.rate = st.bs.din[1:0];
      next_st.density = ~low_rate(st.bs.din[1:0]);
      if (mode == DSR_LEGACY) begin
        next_st.precomp = st.bs.din[DSR_PRECOMP_BIT];
      end
    end
    next_st.dout = 8'h00;
    next_st.doe = 8'h00;
    if (view_read) begin
      next_st.dout = input_view(mode, st.chg, st.rate, st.precomp,
                                dma_gate_enable);
      if (mode == DSR_BASE) begin
        next_st.doe = 8'h80;
      end else begin
        next_st.doe = 8'hff;
      end
    end else if (data_read) begin
      next_st.dout = st0_byte;
      next_st.doe = 8'hff;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // hardware reset values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st.b1 <= BUS_IDLE;
      st.b2 <= BUS_IDLE;
      st.b3 <= BUS_IDLE;
      st.bs <= BUS_IDLE;
      st.wr_prev <= 1'b1;
      st.chg_sync <= 3'h0;
      st.chg <= 1'b0;
      st.trk_sync <= 3'h0;
      st.trk <= 1'b0;
      st.rate <= DSR_RATE_RST;
      st.precomp <= DSR_PRECOMP_RST;
      st.density <= DSR_DENS_RST;
      st.dout <= 8'h00;
      st.doe <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_dout = st.dout;
  assign host_doe = st.doe;
  assign density_select_pin = st.density;
  assign rate_select = st.rate;
  assign precomp_off = st.precomp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rate_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_write |=> st.rate == $past(st.bs.din[1:0]))
    else $error("rate select not loaded by config write");

  base_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_BASE |=> host_doe == 8'h80)
    else $error("baseline read drives low bits");

  chg_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read |=> host_dout[7] == !$past(st.chg))
    else $error("disk change bit not inverted");

  enh_view_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_ENH
    |=> host_dout[6:1] == {4'hf, $past(st.rate)})
    else $error("enhanced view bits wrong");

  enh_dens_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_ENH && st.rate inside {2'h0, 2'h3}
    |=> host_dout[0] == 1'b0)
    else $error("enhanced density flag high at fast rate");

  legacy_view_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_LEGACY
    |=> host_dout[6:0] == {3'h0, $past(dma_gate_enable),
                           $past(st.precomp), $past(st.rate)})
    else $error("legacy view bits wrong");

  soft_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    soft_reset && !cfg_write |=> $stable(st.rate) && $stable(st.precomp))
    else $error("soft reset changed rate or precomp");

  precomp_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_write && mode != DSR_LEGACY |=> $stable(st.precomp))
    else $error("precomp stored outside legacy mode");

  dens_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_write |=> ##1 density_select_pin == ~(rate_select[1] ^ rate_select[0]))
    else $error("density pin does not follow rate");

  read_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_write |=> $stable(st.rate))
    else $error("rate changed without config write");

  status_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    data_read |=> host_doe == 8'hff && host_dout == $past(st0_byte))
    else $error("status byte not presented");

  refuse_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !view_read && !data_read |=> host_doe == 8'h00)
    else $error("bus driven outside an accepted read");

  base_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_BASE |=> host_dout[6:0] == 7'h00)
    else $error("baseline read carries low bits");

  enh_slow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_ENH && st.rate inside {2'h1, 2'h2}
    |=> host_dout[0] == 1'b1)
    else $error("enhanced density flag low at slow rate");

  precomp_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_write && mode == DSR_LEGACY
    |=> precomp_off == $past(st.bs.din[DSR_PRECOMP_BIT]))
    else $error("precomp flag not stored in legacy mode");

  base_read_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_BASE);
  enh_read_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    view_read && mode == DSR_ENH);
  leg_write_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg_write && mode == DSR_LEGACY ##[1:20] view_read);
  st0_read_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    data_read);

endmodule : dsr_regs

// File: tb/dsr_host.sv
// host processor model driving the register bus pins
`timescale 1ns/10ps
module dsr_host import dsr_pkg::*; (
  // clock
  input wire logic mclk,
  // register bus
  output dsr_bus_s bus,
  input wire logic [7:0] dout,
  input wire logic [7:0] doe
);
  initial begin
    bus = '{addr: 10'h000, rd_n: 1'b1, wr_n: 1'b1, din: 8'h00};
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    input dsr_mode_e m);
    logic [7:0] msk;
    msk = (m == DSR_LEGACY) ? 8'h07 : 8'h03;
    @(posedge mclk);
    bus <= '{addr: a, rd_n: 1'b1, wr_n: 1'b0, din: d & msk};
    repeat (8) @(posedge mclk);
    bus <= '{addr: ~a, rd_n: 1'b1, wr_n: 1'b1, din: ~d};
    repeat (6) @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic [7:0] e);
    @(posedge mclk);
    bus <= '{addr: a, rd_n: 1'b0, wr_n: 1'b1, din: 8'h5a};
    repeat (8) @(posedge mclk);
    #1;
    d = dout;
    e = doe;
    @(posedge mclk);
    bus <= '{addr: ~a, rd_n: 1'b1, wr_n: 1'b1, din: 8'ha5};
    repeat (7) @(posedge mclk);
  endtask : rd
endmodule : dsr_host

// File: tb/dsr_regs_tb.sv
// self-checking testbench for the rate and input status registers
`timescale 1ns/10ps
module dsr_regs_tb import dsr_pkg::*;;
  logic mclk, nrst, soft_reset, dma_gate_enable, result_phase;
  logic disk_changed, track_zero_pin, density_select_pin, precomp_off;
  dsr_bus_s host_bus;
  logic [7:0] host_dout, host_doe;
  dsr_mode_e mode;
  dsr_st0_src_s st0_src;
  logic [1:0] rate_select;
  int mismatches, total_checks, cycles;

  dsr_regs dsr_regs_inst (.mclk(mclk), .nrst(nrst), .host_bus(host_bus),
    .host_dout(host_dout), .host_doe(host_doe), .mode(mode),
    .soft_reset(soft_reset), .dma_gate_enable(dma_gate_enable),
    .result_phase(result_phase), .disk_changed(disk_changed),
    .track_zero_pin(track_zero_pin),
    .density_select_pin(density_select_pin), .st0_src(st0_src),
    .rate_select(rate_select), .precomp_off(precomp_off));
  dsr_host dsr_host_inst (.mclk(mclk), .bus(host_bus), .dout(host_dout),
    .doe(host_doe));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic view(input logic [9:0] a, input logic [7:0] ed,
                      input logic [7:0] ee);
    logic [7:0] d, e;
    dsr_host_inst.rd(a, d, e);
    chk("output enable", ee, e);
    chk("read data", ed, d & e);
  endtask : view

  task automatic pins(input logic [1:0] r, input logic pc, input logic dn);
    chk("rate select", {6'h00, r}, {6'h00, rate_select});
    chk("precomp off", {7'h00, pc}, {7'h00, precomp_off});
    chk("density pin", {7'h00, dn}, {7'h00, density_select_pin});
  endtask : pins

  task automatic pulse(input int which);
    @(posedge mclk);
    st0_src.recal_start <= (which == 0);
    st0_src.step <= (which == 1);
    st0_src.cmd_start <= (which == 2);
    st0_src.past_zero <= (which == 3);
    @(posedge mclk);
    st0_src <= '0;
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    pins(2'h2, 1'b0, 1'b1);
    mode <= DSR_ENH;
    view(DSR_ADDR_INPUT_VIEW, 8'hfd, 8'hff);
  endtask : t_reset

  task automatic t_base;
    mode <= DSR_BASE;
    for (int c = 0; c < 2; c++) begin
      disk_changed <= c[0];
      view(DSR_ADDR_INPUT_VIEW, {~c[0], 7'h00}, 8'h80);
    end
    disk_changed <= 1'b0;
  endtask : t_base

  task automatic t_rates;
    logic [1:0] r;
    logic hi;
    mode <= DSR_ENH;
    for (int i = 0; i < 4; i++) begin
      r = i[1:0];
      hi = (r == 2'h0 || r == 2'h3);
      dsr_host_inst.wr(DSR_ADDR_RATE_CFG, {6'h00, r}, DSR_ENH);
      pins(r, 1'b0, hi);
      view(DSR_ADDR_INPUT_VIEW, {5'h1f, r, ~hi}, 8'hff);
    end
  endtask : t_rates

  task automatic t_legacy;
    mode <= DSR_LEGACY;
    dma_gate_enable <= 1'b1;
    dsr_host_inst.wr(DSR_ADDR_RATE_CFG, 8'h05, DSR_LEGACY);
    pins(2'h1, 1'b1, 1'b0);
    view(DSR_ADDR_INPUT_VIEW, 8'h8d, 8'hff);
    dma_gate_enable <= 1'b0;
    view(DSR_ADDR_INPUT_VIEW, 8'h85, 8'hff);
  endtask : t_legacy

  task automatic t_soft;
    @(posedge mclk);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    pins(2'h1, 1'b1, 1'b0);
  endtask : t_soft

  task automatic t_status;
    logic [1:0] t;
    result_phase <= 1'b0;
    view(DSR_ADDR_DATA, 8'h00, 8'h00);
    result_phase <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      t = i[1:0];
      st0_src.termination_code <= t;
      st0_src.seek_done <= t[0];
      st0_src.head <= t[1];
      st0_src.drive_number <= ~t;
      view(DSR_ADDR_DATA, {t, t[0], 2'h0, t[1], ~t}, 8'hff);
    end
  endtask : t_status

  task automatic t_fault;
    st0_src <= '0;
    track_zero_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    pulse(0);
    repeat (DSR_RECAL_STEPS - 1) pulse(1);
    view(DSR_ADDR_DATA, 8'h00, 8'hff);
    pulse(1);
    view(DSR_ADDR_DATA, 8'h10, 8'hff);
    pulse(2);
    view(DSR_ADDR_DATA, 8'h00, 8'hff);
    pulse(3);
    view(DSR_ADDR_DATA, 8'h10, 8'hff);
    pulse(2);
    track_zero_pin <= 1'b1;
    pulse(0);
    repeat (DSR_RECAL_STEPS) pulse(1);
    view(DSR_ADDR_DATA, 8'h00, 8'hff);
  endtask : t_fault

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    mode = DSR_BASE;
    soft_reset = 1'b0;
    dma_gate_enable = 1'b0;
    result_phase = 1'b0;
    disk_changed = 1'b0;
    track_zero_pin = 1'b1;
    st0_src = '0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_base();
    t_rates();
    t_legacy();
    t_soft();
    t_status();
    t_fault();
    wrap_up();
  end
endmodule : dsr_regs_tb
